// ### design/pms_sequencer.sv
// Purpose: sequences normal, low speed and deep sleep modes, gates clocks and supplies
// Assumes: mclk is always on; clock enables and supply enables feed external gates
// Notes:   wdt and rtc events come from mclk logic and are not synchronised
// How it works
// R01 - low speed mode selects low-frequency crystal, divided per sys_clk_div_sel
// R02 - meter_unit_off resets to one, metering and adc clocks off
// R03 - temp, lcd, spi, i2c clocks gated by own bits; lcd/spi/i2c reset off
// R04 - high-frequency oscillator off by default, enabled by primary_osc_on
// R05 - temp, adc, brownout, lvd, lcd supplies each switched by own bit
// R06 - normal mode selects high-frequency crystal, divided per sys_clk_div_sel
// R07 - software clears meter_unit_off in normal mode to run metering
// R08 - software enables second current adc channel separately for anti-tamper
// R09 - deep sleep stops system clock, core and all peripheral clocks except lcd
// R10 - low-frequency oscillator keeps running in deep sleep for the rtc
// R11 - rc oscillator in sleep follows rc_osc_keep_in_sleep; watchdog needs it
// R12 - lcd state in sleep is lcd_off captured at entry
// R13 - external ram and meter contents lost in sleep; registers reinitialised
// R14 - brownout state in sleep from brownout_off and brownout_in_sleep at entry
// R15 - oscillator, sram, por, rtc, watchdog supplies stay on in sleep
// R16 - normal to low speed switches clock source to low frequency
// R17 - low speed to normal switches clock source to high frequency
// R18 - key 101101, ctl a 1, ctl b 0, then command 0x36 enters sleep
// R19 - sleep exits only by wake-up reset into low speed, seven sources
// R20 - wake reset sets flag, restarts at 0000H, resets all but flag
// R21 - four wake pins share two lines chosen by rx_wake_route
// R22 - selected wake pin low at least 100 ns wakes, no service routine; code needs the pin low at two successive rising mclk edges
// R23 - reading reset status clears wake_reset_flag
// R24 - command 0x36 with wrong key is illegal and resets the device
module pms_sequencer
(
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  // power-down bits
  input  wire logic                    pd_wr,
  input  wire logic [pms_pkg::PD_W-1:0] pd_wdata,
  output logic [pms_pkg::PD_W-1:0]     pd_rdata,
  // configuration
  input  wire logic                    cfg_wr,
  input  wire logic                    sys_clk_div_sel,
  input  wire logic                    primary_osc_on,
  input  wire logic                    rc_osc_keep_in_sleep,
  input  wire logic                    brownout_in_sleep,
  input  wire logic                    second_current_adc_on,
  input  wire logic [1:0]              rx_wake_route,
  input  wire logic [7:0]              rtc_irq_mask,
  // sleep key and command
  input  wire logic                    key_wr,
  input  wire logic [7:0]              key_wdata,
  output logic [7:0]                   key_rdata,
  input  wire logic                    cmd_wr,
  input  wire logic [7:0]              cmd_wdata,
  // mode switch requests
  input  wire logic                    req_normal,
  input  wire logic                    req_low_speed,
  // reset status
  input  wire logic                    rst_stat_rd,
  output logic                         wake_reset_flag,
  // wake sources
  input  wire logic                    int0_pin_n,
  input  wire logic                    int1_pin_n,
  input  wire logic                    rx0_pin,
  input  wire logic                    rx1_pin,
  input  wire logic                    rst_pin_n,
  input  wire logic                    wdt_overflow,
  input  wire logic [7:0]              rtc_irq_src,
  // mode and system clock
  output pms_pkg::pms_mode_e           mode,
  output logic                         sys_clk_run,
  output logic                         sys_clk_sel_hf,
  output logic                         sys_clk_div2,
  output logic                         hf_osc_en,
  output logic                         lf_osc_en,
  output logic                         rc_osc_en,
  output logic                         wdt_en,
  // clock enables
  output logic                         core_clk_en,
  output logic                         meter_clk_en,
  output logic [2:0]                   adc_clk_en,
  output logic                         temp_clk_en,
  output logic                         lcd_clk_en,
  output logic                         spi_clk_en,
  output logic                         i2c_clk_en,
  output logic                         carrier_clk_en,
  // supply enables
  output logic                         temp_pwr_en,
  output logic                         adc_pwr_en,
  output logic                         brownout_pwr_en,
  output logic                         lvd_pwr_en,
  output logic                         lcd_pwr_en,
  output logic [4:0]                   always_on_pwr_en,
  output logic                         xram_keep,
  // reset requests to the core
  output logic                         wake_reset,
  output logic                         illegal_reset,
  output logic [15:0]                  core_restart_addr
);

  pms_pkg::pms_mode_e      mode_q;
  logic [pms_pkg::PD_W-1:0] pd_q;
  logic [7:0]              key_q;
  logic                    div_sel_q;
  logic                    hf_on_q;
  logic                    rc_keep_q;
  logic                    bor_sleep_cfg_q;
  logic                    adc2_on_q;
  logic [1:0]              route_q;
  logic [7:0]              rtc_mask_q;
  logic                    lcd_keep_off_q;
  logic                    rc_sleep_q;
  logic                    bor_sleep_q;
  logic                    flag_q;
  logic                    wake_reset_q;
  logic                    illegal_reset_q;
  logic [1:0]              low_cnt_q [2];
  logic [2:0]              out_clk_q;
  logic [2:0]              osc_q;
  logic [9:0]              clk_en_q;
  logic [5:0]              pwr_q;
  logic                    in_sleep;
  logic                    cmd_hit;
  logic                    key_ok;
  logic                    sleep_go;
  logic                    illegal;
  logic                    wake_evt;
  logic                    soft_rst;
  logic [1:0]              line_n;
  logic [1:0]              line_wake;
  logic [pms_pkg::PIN_N-1:0] pin_raw;
  logic [pms_pkg::PIN_N-1:0] pin_clean;

  // pins pass the three-stage filter before any decision
  pms_pin_if pin_bus [pms_pkg::PIN_N] ();

  assign pin_raw = {rst_pin_n, rx1_pin, rx0_pin, int1_pin_n, int0_pin_n};

  for (genvar g = 0; g < pms_pkg::PIN_N; g++)
  begin : g_pin
    assign pin_bus[g].raw = pin_raw[g];
    assign pin_clean[g]   = pin_bus[g].clean;
    pms_pin_sync u_sync
    (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .pin     (pin_bus[g])
    );
  end

  assign in_sleep = (mode_q == pms_pkg::PMS_DEEP_SLEEP);
  assign cmd_hit  = cmd_wr && (cmd_wdata == pms_pkg::SLEEP_CMD) && !in_sleep;
  assign key_ok   = (key_q[7:pms_pkg::KEY_LSB] == pms_pkg::SLEEP_KEY);
  // a valid key with wrong ctl bits is ignored rather than acted on
  assign sleep_go = cmd_hit && key_ok && key_q[pms_pkg::KEY_CTL_A]
                    && !key_q[pms_pkg::KEY_CTL_B]; // R18
  assign illegal  = cmd_hit && !key_ok; // R24

  // two shared lines, each fed by its int pin or its rx pin
  assign line_n[0] = route_q[0] ? pin_clean[pms_pkg::PIN_RX0]
                                : pin_clean[pms_pkg::PIN_INT0]; // R21
  assign line_n[1] = route_q[1] ? pin_clean[pms_pkg::PIN_RX1]
                                : pin_clean[pms_pkg::PIN_INT1]; // R21

  // low-time counters saturate at the least pulse length
  for (genvar l = 0; l < 2; l++)
  begin : g_line
    always_ff @(posedge mclk or posedge sys_rst)
    begin
      if (sys_rst)
        low_cnt_q[l] <= 2'd0;
      else if (line_n[l] || !in_sleep)
        low_cnt_q[l] <= 2'd0;
      else if (low_cnt_q[l] < 2'(pms_pkg::WAKE_PULSE_CYC))
        low_cnt_q[l] <= low_cnt_q[l] + 2'd1;
    end
    assign line_wake[l] = (low_cnt_q[l] >= 2'(pms_pkg::WAKE_PULSE_CYC)); // R22
  end

  // the watchdog can only wake if the rc oscillator was kept running
  assign wake_evt = in_sleep && (|line_wake || !pin_clean[pms_pkg::PIN_RST]
                    || (wdt_overflow && rc_sleep_q)
                    || |(rtc_irq_src & rtc_mask_q)); // R19
  assign soft_rst = wake_evt || illegal; // R20 R24

  // mode sequencing
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      mode_q <= pms_pkg::PMS_LOW_SPEED;
    else if (soft_rst)
      mode_q <= pms_pkg::PMS_LOW_SPEED; // R19
    else if (sleep_go)
      mode_q <= pms_pkg::PMS_DEEP_SLEEP; // R18
    else
    begin
      unique case (mode_q)
        pms_pkg::PMS_NORMAL:
          if (req_low_speed)
            mode_q <= pms_pkg::PMS_LOW_SPEED; // R16
        pms_pkg::PMS_LOW_SPEED:
          if (req_normal && hf_on_q)
            mode_q <= pms_pkg::PMS_NORMAL; // R17
        pms_pkg::PMS_DEEP_SLEEP:
          mode_q <= pms_pkg::PMS_DEEP_SLEEP;
        default:
          mode_q <= pms_pkg::PMS_LOW_SPEED;
      endcase
    end
  end

  // power-down bits; wake and illegal resets reload the reset image
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      pd_q <= pms_pkg::PD_RST; // R02 R03
    else if (soft_rst)
      pd_q <= pms_pkg::PD_RST; // R20
    else if (pd_wr && !in_sleep)
      pd_q <= pd_wdata; // R07
  end

  // configuration bits
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_sel_q       <= 1'b0;
      hf_on_q         <= 1'b0;
      rc_keep_q       <= 1'b0;
      bor_sleep_cfg_q <= 1'b0;
      adc2_on_q       <= 1'b0;
      route_q         <= pms_pkg::ROUTE_RST;
      rtc_mask_q      <= pms_pkg::RTC_MASK_RST;
    end
    else if (soft_rst)
    begin
      div_sel_q       <= 1'b0;
      hf_on_q         <= 1'b0; // R04
      rc_keep_q       <= 1'b0;
      bor_sleep_cfg_q <= 1'b0;
      adc2_on_q       <= 1'b0;
      route_q         <= pms_pkg::ROUTE_RST;
      rtc_mask_q      <= pms_pkg::RTC_MASK_RST;
    end
    else if (cfg_wr && !in_sleep)
    begin
      div_sel_q       <= sys_clk_div_sel;
      hf_on_q         <= primary_osc_on;
      rc_keep_q       <= rc_osc_keep_in_sleep;
      bor_sleep_cfg_q <= brownout_in_sleep;
      adc2_on_q       <= second_current_adc_on; // R08
      route_q         <= rx_wake_route;
      rtc_mask_q      <= rtc_irq_mask;
    end
  end

  // sleep key
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      key_q <= pms_pkg::KEY_RST;
    else if (soft_rst)
      key_q <= pms_pkg::KEY_RST;
    else if (key_wr && !in_sleep)
      key_q <= key_wdata;
  end

  // settings frozen at sleep entry so later writes cannot disturb sleep
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lcd_keep_off_q <= 1'b1;
      rc_sleep_q     <= 1'b0;
      bor_sleep_q    <= 1'b0;
    end
    else if (sleep_go)
    begin
      lcd_keep_off_q <= pd_q[pms_pkg::PD_LCD]; // R12
      rc_sleep_q     <= rc_keep_q; // R11
      bor_sleep_q    <= !pd_q[pms_pkg::PD_BOR] && bor_sleep_cfg_q; // R14
    end
  end

  // wake flag survives the wake reset; a set wins over a read clear
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      flag_q <= 1'b0;
    else if (wake_evt)
      flag_q <= 1'b1; // R20
    else if (rst_stat_rd)
      flag_q <= 1'b0; // R23
  end

  // reset pulses to the core; it restarts without taking the interrupt
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wake_reset_q    <= 1'b0;
      illegal_reset_q <= 1'b0;
    end
    else
    begin
      wake_reset_q    <= wake_evt; // R22
      illegal_reset_q <= illegal; // R24
    end
  end

  // system clock source and oscillators
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      out_clk_q <= 3'b001;
      osc_q     <= 3'b110;
    end
    else
    begin
      out_clk_q[0] <= !in_sleep; // R09
      out_clk_q[1] <= (mode_q == pms_pkg::PMS_NORMAL); // R06 R16 R17
      out_clk_q[2] <= div_sel_q; // R01 R06
      osc_q[0]     <= hf_on_q && !in_sleep; // R04
      osc_q[1]     <= 1'b1; // R10
      osc_q[2]     <= in_sleep ? rc_sleep_q : 1'b1; // R11
    end
  end

  // clock enables: {carrier, i2c, spi, lcd, temp, adc[2:0], meter, core}
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      clk_en_q <= 10'h000;
    else
    begin
      clk_en_q[0]   <= !in_sleep; // R09
      clk_en_q[1]   <= !in_sleep && !pd_q[pms_pkg::PD_METER]; // R02
      clk_en_q[2]   <= !in_sleep && !pd_q[pms_pkg::PD_METER];
      clk_en_q[3]   <= !in_sleep && !pd_q[pms_pkg::PD_METER] && adc2_on_q; // R08
      clk_en_q[4]   <= !in_sleep && !pd_q[pms_pkg::PD_METER];
      clk_en_q[5]   <= !in_sleep && !pd_q[pms_pkg::PD_TEMP]; // R03
      clk_en_q[6]   <= in_sleep ? !lcd_keep_off_q : !pd_q[pms_pkg::PD_LCD]; // R12
      clk_en_q[7]   <= !in_sleep && !pd_q[pms_pkg::PD_SPI]; // R03
      clk_en_q[8]   <= !in_sleep && !pd_q[pms_pkg::PD_I2C]; // R03
      clk_en_q[9]   <= !in_sleep; // R09
    end
  end

  // supply enables: {xram, lcd, lvd, brownout, adc, temp}
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      pwr_q <= 6'h00;
    else
    begin
      pwr_q[0] <= !pd_q[pms_pkg::PD_TEMP]; // R05
      pwr_q[1] <= !pd_q[pms_pkg::PD_METER] && !in_sleep; // R05
      pwr_q[2] <= in_sleep ? bor_sleep_q : !pd_q[pms_pkg::PD_BOR]; // R14
      pwr_q[3] <= !pd_q[pms_pkg::PD_LVD]; // R05
      pwr_q[4] <= in_sleep ? !lcd_keep_off_q : !pd_q[pms_pkg::PD_LCD]; // R12
      pwr_q[5] <= !in_sleep; // R13
    end
  end

  assign mode              = mode_q;
  assign pd_rdata          = pd_q;
  assign key_rdata         = key_q;
  assign wake_reset_flag   = flag_q;
  assign sys_clk_run       = out_clk_q[0];
  assign sys_clk_sel_hf    = out_clk_q[1];
  assign sys_clk_div2      = out_clk_q[2];
  assign hf_osc_en         = osc_q[0];
  assign lf_osc_en         = osc_q[1];
  assign rc_osc_en         = osc_q[2];
  assign wdt_en            = osc_q[2]; // R11
  assign core_clk_en       = clk_en_q[0];
  assign meter_clk_en      = clk_en_q[1];
  assign adc_clk_en        = clk_en_q[4:2];
  assign temp_clk_en       = clk_en_q[5];
  assign lcd_clk_en        = clk_en_q[6];
  assign spi_clk_en        = clk_en_q[7];
  assign i2c_clk_en        = clk_en_q[8];
  assign carrier_clk_en    = clk_en_q[9];
  assign temp_pwr_en       = pwr_q[0];
  assign adc_pwr_en        = pwr_q[1];
  assign brownout_pwr_en   = pwr_q[2];
  assign lvd_pwr_en        = pwr_q[3];
  assign lcd_pwr_en        = pwr_q[4];
  assign xram_keep         = pwr_q[5];
  assign always_on_pwr_en  = 5'h1f; // R15
  assign wake_reset        = wake_reset_q;
  assign illegal_reset     = illegal_reset_q;
  assign core_restart_addr = pms_pkg::RESTART_ADDR; // R20

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_sleep_entry: assert property (sleep_go |=> mode_q == pms_pkg::PMS_DEEP_SLEEP
                                  ##1 !sys_clk_run) // R18
    else $error("sleep entry not taken");
  a_bad_key: assert property (illegal |=> illegal_reset
                              && mode_q == pms_pkg::PMS_LOW_SPEED
                              && pd_q == pms_pkg::PD_RST) // R24
    else $error("illegal command did not reset");
  a_sleep_clk_stop: assert property (in_sleep |=> !core_clk_en && !spi_clk_en
                                     && !meter_clk_en && !carrier_clk_en) // R09
    else $error("clocks run in sleep");
  a_wake_exit: assert property (wake_evt |=> mode_q == pms_pkg::PMS_LOW_SPEED
                                && wake_reset && wake_reset_flag) // R19
    else $error("wake reset missing");
  a_flag_clear: assert property (rst_stat_rd && !wake_evt |=> !wake_reset_flag) // R23
    else $error("flag not cleared by read");
  a_hf_select: assert property (mode_q == pms_pkg::PMS_NORMAL
                                |=> sys_clk_sel_hf && sys_clk_run) // R06
    else $error("normal mode not on high frequency");
  a_lf_select: assert property (mode_q == pms_pkg::PMS_LOW_SPEED
                                |=> !sys_clk_sel_hf && sys_clk_div2 == $past(div_sel_q)) // R01
    else $error("low speed clock wrong");
  a_no_hf_switch: assert property (mode_q == pms_pkg::PMS_LOW_SPEED && !hf_on_q
                                   && !sleep_go |=> mode_q == pms_pkg::PMS_LOW_SPEED) // R17
    else $error("switched to normal without oscillator");
  a_lcd_hold: assert property (in_sleep && $past(in_sleep) && !wake_evt
                               |=> $stable(lcd_pwr_en)) // R12
    else $error("lcd changed in sleep");
  a_pin_wake: assert property (in_sleep && $fell(line_n[0]) && !soft_rst
                               |-> ##[1:2] wake_reset) // R22
    else $error("pin pulse did not wake");

  c_sleep: cover property (sleep_go ##1 in_sleep);
  c_wake: cover property (in_sleep ##1 wake_evt ##1 wake_reset);
  c_normal: cover property (mode_q == pms_pkg::PMS_LOW_SPEED
                            ##1 mode_q == pms_pkg::PMS_NORMAL);

endmodule

// ### design/pms_pkg.sv
// Purpose: shared constants and types of the power mode sequencer
// Assumes: mclk is an always-on 10 MHz clock that keeps running in deep sleep
// Notes:   power-down bit positions follow the order of the pd_* vectors
package pms_pkg;

  typedef enum logic [1:0]
  {
    PMS_NORMAL,
    PMS_LOW_SPEED,
    PMS_DEEP_SLEEP
  } pms_mode_e;

  // power-down vector field positions
  localparam int PD_SPI   = 0;
  localparam int PD_I2C   = 1;
  localparam int PD_LCD   = 2;
  localparam int PD_LVD   = 3;
  localparam int PD_BOR   = 4;
  localparam int PD_METER = 5;
  localparam int PD_TEMP  = 6;
  localparam int PD_W     = 7;

  // reset value of the power-down vector: meter, lcd, i2c, spi off
  localparam logic [PD_W-1:0] PD_RST = 7'h27;

  // sleep key vector: key in [7:2], ctl_a in [1], ctl_b in [0]
  localparam int KEY_CTL_B = 0;
  localparam int KEY_CTL_A = 1;
  localparam int KEY_LSB   = 2;
  localparam logic [5:0] SLEEP_KEY     = 6'h2d;
  localparam logic [7:0] KEY_RST       = 8'h00;
  localparam logic [7:0] SLEEP_CMD     = 8'h36;
  localparam logic [1:0] ROUTE_RST     = 2'h0;
  localparam logic [7:0] RTC_MASK_RST  = 8'h00;
  localparam logic [15:0] RESTART_ADDR = 16'h0000;

  // wake pin low pulse, least time
  localparam int CLK_PERIOD_NS  = 100;
  localparam int WAKE_PULSE_NS  = 100;
  localparam int WAKE_PULSE_RAW = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_PULSE_CYC = (WAKE_PULSE_RAW < 1) ? 1 : WAKE_PULSE_RAW;

  // synchronised pin indices
  localparam int PIN_INT0 = 0;
  localparam int PIN_INT1 = 1;
  localparam int PIN_RX0  = 2;
  localparam int PIN_RX1  = 3;
  localparam int PIN_RST  = 4;
  localparam int PIN_N    = 5;

endpackage

// ### design/pms_pin_if.sv
// Purpose: carries one raw pin level into its synchroniser and back
// Assumes: pins idle high
// Notes:   one instance per wake pin
interface pms_pin_if;
  logic raw;
  logic clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// ### design/pms_pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for one pin
// Assumes: pin idles high
// Notes:   a change is taken only once stages two and three agree
module pms_pin_sync
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // pin
  pms_pin_if.sync   pin
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic clean_q;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end
    else
    begin
      s1_q <= pin.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // only stages two and three are looked at, stage one may be metastable
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      clean_q <= 1'b1;
    else if (s2_q == s3_q)
      clean_q <= s3_q;
  end

  assign pin.clean = clean_q;

endmodule

// ### test/pms_wake_model.sv
// Purpose: far side wake pins of the power mode sequencer
// Assumes: pulses start just after a rising mclk edge
// Notes:   pin order int0, int1, rx0, rx1, reset; pull-ups hold them high
module pms_wake_model
(
  // clock
  input  wire logic       mclk,
  // wake pins
  output logic [4:0]      pins
);
  timeunit 1ns;
  timeprecision 1ns;

  initial pins = 5'h1f;

  // low pulse of n cycles; released pins return to the pull-up level
  task automatic pulse(input int idx, input int n);
    pins[idx] = 1'b0;
    repeat (n) @(posedge mclk);
    #1 pins[idx] = 1'b1;
  endtask
endmodule

// ### test/test_power_mode_sequencer.sv
// Purpose: self-checking bench of the power mode sequencer
// Assumes: strobes last one cycle; wake pins idle high
// Notes:   random power-down vectors, every wake source in turn
module test_power_mode_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, sys_rst, pd_wr, cfg_wr, key_wr, cmd_wr, req_normal, req_low_speed;
  logic rst_stat_rd, wdt_overflow, sys_clk_div_sel, primary_osc_on, rc_osc_keep_in_sleep;
  logic brownout_in_sleep, second_current_adc_on, wake_reset_flag, sys_clk_run;
  logic sys_clk_sel_hf, sys_clk_div2, hf_osc_en, lf_osc_en, rc_osc_en, wdt_en, core_clk_en;
  logic meter_clk_en, temp_clk_en, lcd_clk_en, spi_clk_en, i2c_clk_en, temp_pwr_en;
  logic adc_pwr_en, brownout_pwr_en, lvd_pwr_en, lcd_pwr_en, wake_reset, illegal_reset;
  logic carrier_clk_en, xram_keep;
  logic [1:0]  rx_wake_route;
  logic [2:0]  adc_clk_en;
  logic [4:0]  pins, always_on_pwr_en;
  logic [6:0]  pd_wdata, pd_rdata, v;
  logic [7:0]  rtc_irq_mask, rtc_irq_src, key_wdata, key_rdata, cmd_wdata;
  logic [15:0] core_restart_addr;
  pms_pkg::pms_mode_e mode;
  int          err_total, n_tests;

  pms_wake_model u_wake (.mclk, .pins);

  pms_sequencer u_dut (.mclk, .sys_rst, .pd_wr, .pd_wdata, .pd_rdata, .cfg_wr, .sys_clk_div_sel,
    .primary_osc_on, .rc_osc_keep_in_sleep, .brownout_in_sleep, .second_current_adc_on,
    .rx_wake_route, .rtc_irq_mask, .key_wr, .key_wdata, .key_rdata, .cmd_wr, .cmd_wdata,
    .req_normal, .req_low_speed, .rst_stat_rd, .wake_reset_flag, .int0_pin_n(pins[0]),
    .int1_pin_n(pins[1]), .rx0_pin(pins[2]), .rx1_pin(pins[3]), .rst_pin_n(pins[4]),
    .wdt_overflow, .rtc_irq_src, .mode, .sys_clk_run, .sys_clk_sel_hf, .sys_clk_div2,
    .hf_osc_en, .lf_osc_en, .rc_osc_en, .wdt_en, .core_clk_en, .meter_clk_en, .adc_clk_en,
    .temp_clk_en, .lcd_clk_en, .spi_clk_en, .i2c_clk_en, .carrier_clk_en, .temp_pwr_en,
    .adc_pwr_en, .brownout_pwr_en, .lvd_pwr_en, .lcd_pwr_en, .always_on_pwr_en, .xram_keep,
    .wake_reset, .illegal_reset, .core_restart_addr);

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one-cycle strobe: 0 power-down, 1 config, 2 key, 3 command
  task automatic wr(input int k, input logic [7:0] d);
    step();
    pd_wdata = d[6:0];
    key_wdata = d;
    cmd_wdata = d;
    {pd_wr, cfg_wr, key_wr, cmd_wr} = {k == 0, k == 1, k == 2, k == 3};
    step();
    {pd_wr, cfg_wr, key_wr, cmd_wr} = 4'h0;
  endtask

  task automatic cfg(input logic hf, input logic rc, input logic [1:0] rt, input logic [7:0] m);
    primary_osc_on = hf;
    rc_osc_keep_in_sleep = rc;
    rx_wake_route = rt;
    rtc_irq_mask = m;
    sys_clk_div_sel = $urandom;
    second_current_adc_on = $urandom;
    brownout_in_sleep = $urandom;
    wr(1, 8'h00);
  endtask

  // reset pulses are one cycle wide, so each edge is looked at
  task automatic wait_rst(input logic ill);
    int i;
    for (i = 0; i < 20 && (ill ? illegal_reset : wake_reset) !== 1'b1; i++)
      step();
    if (i == 20)
    begin
      chk(16'h0000, 16'h0001);
      conclude();
    end
    chk({wake_reset_flag, mode}, {!ill, pms_pkg::PMS_LOW_SPEED});
    chk(pd_rdata, pms_pkg::PD_RST);
  endtask

  task automatic sw(input logic n);
    req_normal = n;
    req_low_speed = !n;
    step();
    {req_normal, req_low_speed} = 2'h0;
    step();
    step();
  endtask

  task automatic sleep(input logic l);
    wr(2, 8'hb6);
    wr(3, 8'h36);
    chk(mode, pms_pkg::PMS_DEEP_SLEEP);
    step();
    chk({sys_clk_run, core_clk_en, spi_clk_en, carrier_clk_en, xram_keep, lf_osc_en},
        16'h0001);
    chk({rc_osc_en, wdt_en, lcd_pwr_en}, {rc_osc_keep_in_sleep, rc_osc_keep_in_sleep, !l});
    chk(always_on_pwr_en, 16'h001f);
  endtask

  initial
  begin
    {pd_wr, cfg_wr, key_wr, cmd_wr, req_normal, req_low_speed, rst_stat_rd, wdt_overflow} = 8'h00;
    {sys_clk_div_sel, primary_osc_on, rc_osc_keep_in_sleep, brownout_in_sleep} = 4'h0;
    {second_current_adc_on, rx_wake_route, rtc_irq_mask, rtc_irq_src} = 19'h0_0000;
    {pd_wdata, key_wdata, cmd_wdata} = 23'h00_0000;
    err_total = 0;
    n_tests = 0;
    void'($urandom(32'h52c5_0a7a));
    sys_rst = 1'b1;
    repeat (3) @(posedge mclk);
    #1 sys_rst = 1'b0;
    step();
    chk(pd_rdata, pms_pkg::PD_RST);
    chk({meter_clk_en, adc_clk_en, lcd_clk_en, spi_clk_en, i2c_clk_en, temp_clk_en}, 16'h0001);
    chk({mode, hf_osc_en}, {pms_pkg::PMS_LOW_SPEED, 1'b0});
    chk(core_restart_addr, 16'h0000);
    $display("reset test done");
    repeat (6)
    begin
      v = $urandom;
      cfg(1'b0, 1'b0, 2'h0, 8'h00);
      wr(0, {1'b0, v});
      chk(pd_rdata, v);
      step();
      chk({temp_clk_en, lcd_clk_en, spi_clk_en, i2c_clk_en, meter_clk_en},
          {~v[6], ~v[2], ~v[0], ~v[1], ~v[5]});
      chk({temp_pwr_en, lcd_pwr_en, lvd_pwr_en, brownout_pwr_en, adc_pwr_en},
          {~v[6], ~v[2], ~v[3], ~v[4], ~v[5]});
      chk(adc_clk_en, {~v[5], ~v[5] & second_current_adc_on, ~v[5]});
      chk({carrier_clk_en, xram_keep}, 2'b11);
    end
    $display("power-down test done");
    cfg(1'b1, 1'b0, 2'h0, 8'h00);
    step();
    chk(hf_osc_en, 1'b1);
    sw(1'b1);
    chk({mode, sys_clk_sel_hf, sys_clk_div2}, {pms_pkg::PMS_NORMAL, 1'b1, sys_clk_div_sel});
    sw(1'b0);
    chk({mode, sys_clk_sel_hf, sys_clk_div2}, {pms_pkg::PMS_LOW_SPEED, 1'b0, sys_clk_div_sel});
    wr(2, 8'hb6);
    wr(3, 8'h35);
    step();
    chk({mode, illegal_reset}, {pms_pkg::PMS_LOW_SPEED, 1'b0});
    v = $urandom;
    if (v[5:0] == 6'h2d)
      v[0] = 1'b0;
    wr(2, {v[5:0], 2'b10});
    wr(3, 8'h36);
    wait_rst(1'b1);
    $display("mode and key test done");
    for (int s = 0; s < 7; s++)
    begin
      cfg(1'b0, 1'b1, {s == 3, s == 2}, 8'h04);
      v = $urandom;
      wr(0, {1'b0, v});
      sleep(v[2]);
      chk({brownout_pwr_en, adc_pwr_en}, {~v[4] & brownout_in_sleep, 1'b0});
      // the rx pin sharing an int line is not routed here, so it must not wake
      if (s < 2)
      begin
        u_wake.pulse(s + 2, 2);
        repeat (8) step();
        chk(mode, pms_pkg::PMS_DEEP_SLEEP);
      end
      if (s < 5)
        u_wake.pulse(s, 2);
      else if (s == 5)
        wdt_overflow = 1'b1;
      else
        rtc_irq_src = 8'h04;
      wait_rst(1'b0);
      {wdt_overflow, rtc_irq_src} = 9'h000;
      rst_stat_rd = 1'b1;
      step();
      rst_stat_rd = 1'b0;
      step();
      chk(wake_reset_flag, 1'b0);
      $display("wake source %0d test done", s);
    end
    conclude();
  end
endmodule
